// *** inc/hmi_defs.svh ***
`ifndef HMI_DEFS_SVH
`define HMI_DEFS_SVH
`define HMI_REG_MSG 2'h0
`define HMI_REG_CTRL 2'h1
`define HMI_REG_PCM 2'h2
`define HMI_REG_CMP 2'h3
`define HMI_CTRL_CMPRST 6
`define HMI_CTRL_PCMRST 5
`define HMI_BYTE_CNT 4'h8
`define HMI_ACK_CNT 4'h1
`define HMI_I2C_N1_CNT 4'h7
`define HMI_SPI_N1_CNT 4'h6
`define HMI_SPI_N_CNT 4'h7
`define HMI_FIFO_DEPTH 16
`define HMI_FIFO_THRESH 12
`define HMI_NULL_BYTE 8'h00
`endif

// *** inc/hmi_pkg.sv ***
package hmi_pkg;
	typedef enum logic [2:0] {
		HMI_IDLE = 3'b000,
		HMI_ADDR = 3'b001,
		HMI_ADDR_ACK = 3'b010,
		HMI_READ = 3'b011,
		HMI_RD_ACK = 3'b100,
		HMI_WRITE = 3'b101,
		HMI_WR_ACK = 3'b110,
		HMI_HOLD = 3'b111
	} hmi_state_t;
	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
		logic [1:0] addr;
		logic [7:0] data;
	} hmi_par_bus_t;
	typedef struct packed {
		logic scl;
		logic sda;
		logic sel_n;
	} hmi_ser_pins_t;
	typedef struct packed {
		hmi_ser_pins_t ser;
		hmi_par_bus_t par;
	} hmi_pins_t;
	typedef struct packed {
		logic rsvd7;
		logic cmp_rst;
		logic pcm_rst;
		logic pcm_af;
		logic cmp_af;
		logic in_busy;
		logic out_ready;
		logic rsvd0;
	} hmi_ctrl_t;
endpackage : hmi_pkg

// *** testbench/hmi_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module hmi_host_model import hmi_pkg::*; (
	input wire logic sys_clk,
	input wire logic io_oe,
	input wire logic irq_n,
	output var hmi_par_bus_t par,
	output logic scl,
	output logic sda
);
	logic drv;
	// The data line has a pull-up, so it is low while either side pulls it.
	assign sda = drv & !io_oe;
	initial begin
		par = {3'b111, 2'h0, 8'h00};
		scl = 1'b1;
		drv = 1'b1;
	end
	task automatic pacc(input logic wr, input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		par.addr <= a;
		par.data <= d;
		par.cs_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		par.wr_n <= !wr;
		par.rd_n <= wr;
		repeat (6) @(posedge sys_clk);
		par.wr_n <= 1'b1;
		par.rd_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		par.cs_n <= 1'b1;
		par.data <= ~d;
	endtask : pacc
	task automatic start_i2c();
		#1 drv = 1'b1;
		scl = 1'b1;
		#24 drv = 1'b0;
		#24 scl = 1'b0;
	endtask : start_i2c
	task automatic stop_i2c();
		#12 drv = 1'b0;
		#12 scl = 1'b1;
		#24 drv = 1'b1;
		#24;
	endtask : stop_i2c
	// Interrupt is sampled just before the falling clock edge of each of the eight data bits, not the ack bit.
	task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
		output logic [7:0] iq);
		for (int i = 7; i >= 0; i--) begin
			#12 drv = d[i];
			#12 scl = 1'b1;
			#22 q[i] = sda;
			iq[i] = irq_n;
			#2 scl = 1'b0;
		end
		#12 drv = ack;
		#12 scl = 1'b1;
		#24 scl = 1'b0;
	endtask : xfer
endmodule : hmi_host_model
`default_nettype wire

// *** testbench/tb_host_msg_irq_and_port_status.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_host_msg_irq_and_port_status import hmi_pkg::*; ();
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic mode_parallel = 1'b1;
	logic unsolicited_en = 1'b0;
	logic read_request = 1'b0;
	logic dsp_msg_wr = 1'b0;
	logic [7:0] dsp_msg_data = 8'h00;
	logic dsp_in_rd = 1'b0;
	logic [1:0] fifo_pop = 2'h0;
	hmi_par_bus_t par;
	wire logic scl, sda, io_oe, irq_n, dsp_out_ready, host_in_busy;
	wire logic pcm_af, cmp_af;
	wire logic [7:0] par_data_out, dsp_in_data;
	wire logic [1:0][7:0] fifo_rdata;
	wire logic [1:0] fifo_empty;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	hmi_port #(.FIFO_DEPTH(4), .FIFO_THRESH(3)) hmi_port_inst (.sys_clk(sys_clk),
		.resetn(resetn), .mode_parallel(mode_parallel), .serial_is_i2c(1'b1),
		.unsolicited_en(unsolicited_en), .ctrl_serial_clock(scl), .ctrl_serial_io_in(sda),
		.ctrl_serial_io_out(), .ctrl_serial_io_oe(io_oe), .spi_sel_n(1'b1),
		.spi_data_out(), .par_pins(par), .par_data_out(par_data_out), .par_data_oe(),
		.msg_pending_irq_n(irq_n), .read_request(read_request), .dsp_msg_wr(dsp_msg_wr),
		.dsp_msg_data(dsp_msg_data), .dsp_out_ready(dsp_out_ready), .dsp_in_rd(dsp_in_rd),
		.dsp_in_data(dsp_in_data), .host_in_busy(host_in_busy), .fifo_pop(fifo_pop),
		.fifo_rdata(fifo_rdata), .fifo_empty(fifo_empty), .pcm_fifo_almost_full(pcm_af),
		.cmp_fifo_almost_full(cmp_af), .pcm_port_reset(), .cmp_port_reset());
	hmi_host_model host (.sys_clk(sys_clk), .io_oe(io_oe), .irq_n(irq_n), .par(par),
		.scl(scl), .sda(sda));
	always #2 sys_clk = ~sys_clk;
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic dwr(input logic [7:0] d);
		@(posedge sys_clk);
		dsp_msg_wr <= 1'b1;
		dsp_msg_data <= d;
		@(posedge sys_clk);
		dsp_msg_wr <= 1'b0;
	endtask : dwr
	task automatic t_par_msg();
		dwr(8'hA5);
		tick(3);
		chk(dsp_out_ready, 8'h01);
		chk(irq_n, 8'h00);
		host.pacc(1'b0, 2'h0, 8'h00);
		tick(3);
		chk(par_data_out, 8'hA5);
		chk(dsp_out_ready, 8'h00);
		chk(irq_n, 8'h01);
		host.pacc(1'b1, 2'h0, 8'h3C);
		tick(3);
		chk(dsp_in_data, 8'h3C);
		host.pacc(1'b0, 2'h1, 8'h00);
		tick(3);
		chk(par_data_out, 8'h04);
		dsp_in_rd <= 1'b1;
		tick(1);
		dsp_in_rd <= 1'b0;
		tick(3);
		chk(host_in_busy, 8'h00);
	endtask : t_par_msg
	task automatic t_fifo();
		for (int k = 0; k < 2; k++) begin
			for (int j = 0; j < 3; j++) host.pacc(1'b1, {1'b1, k[0]}, {4'h1, 4'(j)});
			tick(3);
			chk({pcm_af, cmp_af}, k ? 8'h01 : 8'h02);
			host.pacc(1'b0, {1'b1, k[0]}, 8'h00);
			tick(3);
			chk(par_data_out, 8'h00);
			chk(fifo_rdata[k], 8'h10);
			fifo_pop <= 2'(1 << k);
			tick(1);
			fifo_pop <= 2'h0;
			tick(3);
			chk({pcm_af, cmp_af}, 8'h00);
		end
	endtask : t_fifo
	task automatic t_i2c_sol();
		logic [7:0] q, iq;
		mode_parallel <= 1'b0;
		dwr(8'h5A);
		tick(8);
		chk(irq_n, 8'h01);
		read_request <= 1'b1;
		tick(1);
		read_request <= 1'b0;
		tick(4);
		chk(irq_n, 8'h00);
		host.start_i2c();
		host.xfer(8'h01, 1'b1, q, iq);
		host.xfer(8'hFF, 1'b1, q, iq);
		host.stop_i2c();
		chk(q, 8'h5A);
		chk(iq, 8'h01);
		dwr(8'h77);
		tick(8);
		chk(irq_n, 8'h01);
	endtask : t_i2c_sol
	task automatic t_i2c_uns();
		logic [7:0] q, iq;
		unsolicited_en <= 1'b1;
		tick(6);
		chk(irq_n, 8'h00);
		host.start_i2c();
		host.xfer(8'h01, 1'b1, q, iq);
		fork
			host.xfer(8'hFF, 1'b0, q, iq);
			begin #100; dwr(8'hC3); end
		join
		chk(q, 8'h77);
		chk(iq, 8'h00);
		// The next message lands between clocks N-1 and N of this byte.
		fork
			host.xfer(8'hFF, 1'b0, q, iq);
			begin #384; dwr(8'h99); end
		join
		chk(q, 8'hC3);
		chk(iq, 8'h01);
		host.xfer(8'hFF, 1'b0, q, iq);
		chk(q, 8'h00);
		chk(iq, 8'h00);
		host.xfer(8'hFF, 1'b1, q, iq);
		host.stop_i2c();
		chk(q, 8'h99);
		chk(iq, 8'h01);
		dwr(8'h4D);
		tick(6);
		host.start_i2c();
		host.xfer(8'h01, 1'b1, q, iq);
		// A late arrival followed by a stop: the next read starts with the message itself.
		fork
			host.xfer(8'hFF, 1'b1, q, iq);
			begin #384; dwr(8'h2E); end
		join
		host.stop_i2c();
		chk(q, 8'h4D);
		chk(iq, 8'h01);
		tick(6);
		chk(irq_n, 8'h00);
		host.start_i2c();
		host.xfer(8'h01, 1'b1, q, iq);
		host.xfer(8'hFF, 1'b1, q, iq);
		host.stop_i2c();
		chk(q, 8'h2E);
		chk(iq, 8'h01);
	endtask : t_i2c_uns
	initial begin
		tick(16);
		resetn <= 1'b1;
		tick(4);
		chk(irq_n, 8'h01);
		chk({dsp_out_ready, host_in_busy, fifo_empty}, 8'h03);
		t_par_msg();
		t_fifo();
		t_i2c_sol();
		t_i2c_uns();
		tick(4);
		results();
	end
endmodule : tb_host_msg_irq_and_port_status
`default_nettype wire

// *** verilog/hmi_port.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "hmi_defs.svh"
module hmi_port import hmi_pkg::*; #(
	parameter int FIFO_DEPTH = `HMI_FIFO_DEPTH,
	parameter int FIFO_THRESH = `HMI_FIFO_THRESH
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic mode_parallel,
	input wire logic serial_is_i2c,
	input wire logic unsolicited_en,
	input wire logic ctrl_serial_clock,
	input wire logic ctrl_serial_io_in,
	output logic ctrl_serial_io_out,
	output logic ctrl_serial_io_oe,
	input wire logic spi_sel_n,
	output logic spi_data_out,
	input wire hmi_par_bus_t par_pins,
	output logic [7:0] par_data_out,
	output logic par_data_oe,
	output logic msg_pending_irq_n,
	input wire logic read_request,
	input wire logic dsp_msg_wr,
	input wire logic [7:0] dsp_msg_data,
	output logic dsp_out_ready,
	input wire logic dsp_in_rd,
	output logic [7:0] dsp_in_data,
	output logic host_in_busy,
	input wire logic [1:0] fifo_pop,
	output logic [1:0][7:0] fifo_rdata,
	output logic [1:0] fifo_empty,
	output logic pcm_fifo_almost_full,
	output logic cmp_fifo_almost_full,
	output logic pcm_port_reset,
	output logic cmp_port_reset
);
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam logic [AW:0] LVL_FULL = (AW+1)'(FIFO_DEPTH);
	localparam logic [AW:0] LVL_AF = (AW+1)'(FIFO_THRESH);

	// Three-stage pin synchroniser; a level counts once stages two and three agree.
	hmi_pins_t sync1, sync2, sync3, filt, filt_q;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sync1 <= '1;
			sync2 <= '1;
			sync3 <= '1;
			filt <= '1;
			filt_q <= '1;
		end else begin
			sync1 <= {ctrl_serial_clock, ctrl_serial_io_in, spi_sel_n, par_pins};
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
			filt_q <= filt;
		end
	end

	logic scl_rise, scl_fall, i2c_start, i2c_stop, spi_begin, spi_end;
	logic frame_begin, frame_end, par_wr, par_rd;
	assign scl_rise = filt.ser.scl && !filt_q.ser.scl;
	assign scl_fall = !filt.ser.scl && filt_q.ser.scl;
	assign i2c_start = serial_is_i2c && filt.ser.scl && filt_q.ser.sda && !filt.ser.sda;
	assign i2c_stop = serial_is_i2c && filt.ser.scl && !filt_q.ser.sda && filt.ser.sda;
	assign spi_begin = !serial_is_i2c && filt_q.ser.sel_n && !filt.ser.sel_n;
	assign spi_end = !serial_is_i2c && filt.ser.sel_n;
	assign frame_begin = !mode_parallel && (i2c_start || spi_begin);
	assign frame_end = mode_parallel || i2c_stop || spi_end;
	assign par_wr = mode_parallel && !filt.par.cs_n && filt_q.par.wr_n && !filt.par.wr_n;
	assign par_rd = mode_parallel && !filt.par.cs_n && filt_q.par.rd_n && !filt.par.rd_n;

	hmi_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] rx_sh, tx_sh, out_byte;
	logic rd_dir, null_pend, late, armed, ser_take, ser_push;
	logic in_read, at_n1, at_n, load_tx;
	assign in_read = (state == HMI_READ) || (state == HMI_RD_ACK);
	assign at_n1 = scl_rise && (state == HMI_READ)
		&& (bit_cnt == (serial_is_i2c ? `HMI_I2C_N1_CNT : `HMI_SPI_N1_CNT));
	assign at_n = scl_rise && (serial_is_i2c ? (state == HMI_RD_ACK)
		: (state == HMI_READ && bit_cnt == `HMI_SPI_N_CNT));
	assign load_tx = scl_fall && ((state == HMI_ADDR_ACK && bit_cnt == `HMI_ACK_CNT && rd_dir)
		|| (state == HMI_ADDR && bit_cnt == `HMI_BYTE_CNT && !serial_is_i2c && rx_sh[0])
		|| (state == HMI_READ && bit_cnt == `HMI_BYTE_CNT && !serial_is_i2c)
		|| (state == HMI_RD_ACK && bit_cnt == `HMI_ACK_CNT));
	assign ser_take = load_tx && !null_pend && dsp_out_ready;
	assign ser_push = scl_fall && state == HMI_WRITE && bit_cnt == `HMI_BYTE_CNT;

	// Serial framing: address byte, then read or write bytes, acks in I2C only.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= HMI_IDLE;
			bit_cnt <= '0;
			rx_sh <= '0;
			tx_sh <= '0;
			rd_dir <= 1'b0;
			ctrl_serial_io_oe <= 1'b0;
			spi_data_out <= 1'b0;
		end else if (frame_end) begin
			state <= HMI_IDLE;
			ctrl_serial_io_oe <= 1'b0;
		end else if (frame_begin) begin
			state <= HMI_ADDR;
			bit_cnt <= '0;
			ctrl_serial_io_oe <= 1'b0;
		end else if (scl_rise && state != HMI_IDLE && state != HMI_HOLD) begin
			bit_cnt <= bit_cnt + 4'h1;
			rx_sh <= {rx_sh[6:0], filt.ser.sda};
			if (state == HMI_RD_ACK && filt.ser.sda)
				state <= HMI_HOLD;
		end else if (load_tx) begin
			state <= HMI_READ;
			bit_cnt <= '0;
			tx_sh <= (null_pend || !dsp_out_ready) ? `HMI_NULL_BYTE : out_byte;
			rd_dir <= 1'b1;
			if (null_pend || !dsp_out_ready) begin
				ctrl_serial_io_oe <= serial_is_i2c;
				spi_data_out <= 1'b0;
			end else begin
				ctrl_serial_io_oe <= serial_is_i2c && !out_byte[7];
				spi_data_out <= out_byte[7];
			end
		end else if (scl_fall) begin
			case (state)
				HMI_ADDR: begin
					if (bit_cnt == `HMI_BYTE_CNT) begin
						bit_cnt <= '0;
						rd_dir <= rx_sh[0];
						state <= serial_is_i2c ? HMI_ADDR_ACK : HMI_WRITE;
						ctrl_serial_io_oe <= serial_is_i2c;
					end
				end
				HMI_ADDR_ACK, HMI_WR_ACK: begin
					if (bit_cnt == `HMI_ACK_CNT) begin
						bit_cnt <= '0;
						state <= HMI_WRITE;
						ctrl_serial_io_oe <= 1'b0;
					end
				end
				HMI_WRITE: begin
					if (bit_cnt == `HMI_BYTE_CNT) begin
						bit_cnt <= '0;
						state <= serial_is_i2c ? HMI_WR_ACK : HMI_WRITE;
						ctrl_serial_io_oe <= serial_is_i2c;
					end
				end
				HMI_READ: begin
					if (bit_cnt == `HMI_BYTE_CNT) begin
						bit_cnt <= '0;
						state <= HMI_RD_ACK;
						ctrl_serial_io_oe <= 1'b0;
					end else begin
						tx_sh <= {tx_sh[6:0], 1'b0};
						ctrl_serial_io_oe <= serial_is_i2c && !tx_sh[6];
						spi_data_out <= tx_sh[6];
					end
				end
				default: begin
					state <= state;
				end
			endcase
		end
	end
	assign ctrl_serial_io_out = 1'b0;

	// Outgoing byte holder; a DSP write in the same cycle as a host read wins.
	logic par_msg_rd, par_msg_wr;
	assign par_msg_rd = par_rd && filt.par.addr == `HMI_REG_MSG;
	assign par_msg_wr = par_wr && filt.par.addr == `HMI_REG_MSG;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dsp_out_ready <= 1'b0;
			out_byte <= '0;
		end else if (dsp_msg_wr) begin
			dsp_out_ready <= 1'b1;
			out_byte <= dsp_msg_data;
		end else if (ser_take || par_msg_rd) begin
			dsp_out_ready <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			host_in_busy <= 1'b0;
			dsp_in_data <= '0;
		end else if (par_msg_wr || ser_push) begin
			host_in_busy <= 1'b1;
			dsp_in_data <= par_msg_wr ? filt.par.data : rx_sh;
		end else if (dsp_in_rd) begin
			host_in_busy <= 1'b0;
		end
	end

	// Interrupt line; only the N-1 and N edges of a read may move it mid-read.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			msg_pending_irq_n <= 1'b1;
			armed <= 1'b0;
			late <= 1'b0;
			null_pend <= 1'b0;
		end else begin
			if (read_request)
				armed <= 1'b1;
			if (frame_end)
				null_pend <= 1'b0;
			else if (load_tx)
				null_pend <= 1'b0;
			if (mode_parallel) begin
				msg_pending_irq_n <= !dsp_out_ready;
				late <= 1'b0;
			end else if (in_read) begin
				if (at_n1 && !dsp_out_ready) begin
					msg_pending_irq_n <= 1'b1;
					late <= 1'b1;
					armed <= read_request;
				end else if (at_n && late) begin
					late <= 1'b0;
					if (dsp_out_ready && unsolicited_en) begin
						msg_pending_irq_n <= 1'b0;
						null_pend <= 1'b1;
					end
				end
			end else if (!late) begin
				msg_pending_irq_n <= !(dsp_out_ready && (unsolicited_en || armed));
			end else begin
				late <= 1'b0;
			end
		end
	end

	// Parallel register reads; audio registers read as zero.
	hmi_ctrl_t ctrl_view;
	logic [1:0] port_rst, fifo_push, fifo_af;
	always_comb begin
		ctrl_view = '0;
		ctrl_view.pcm_af = fifo_af[0];
		ctrl_view.cmp_af = fifo_af[1];
		ctrl_view.in_busy = host_in_busy;
		ctrl_view.out_ready = dsp_out_ready;
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			par_data_out <= '0;
			port_rst <= '0;
		end else begin
			if (par_rd) begin
				if (filt.par.addr == `HMI_REG_MSG)
					par_data_out <= out_byte;
				else if (filt.par.addr == `HMI_REG_CTRL)
					par_data_out <= ctrl_view;
				else
					par_data_out <= '0;
			end
			if (par_wr && filt.par.addr == `HMI_REG_CTRL)
				port_rst <= {filt.par.data[`HMI_CTRL_CMPRST], filt.par.data[`HMI_CTRL_PCMRST]};
		end
	end
	assign par_data_oe = mode_parallel && !filt.par.cs_n && !filt.par.rd_n;
	assign pcm_port_reset = port_rst[0];
	assign cmp_port_reset = port_rst[1];
	assign fifo_push[0] = par_wr && filt.par.addr == `HMI_REG_PCM;
	assign fifo_push[1] = par_wr && filt.par.addr == `HMI_REG_CMP;
	assign pcm_fifo_almost_full = fifo_af[0];
	assign cmp_fifo_almost_full = fifo_af[1];

	// Audio FIFOs: index 0 is PCM, 1 is compressed; a push when full is dropped.
	logic [7:0] fifo_mem [2][FIFO_DEPTH];
	for (genvar ch = 0; ch < 2; ch++) begin : g_fifo
		logic [AW-1:0] wp, rp;
		logic [AW:0] lvl;
		logic do_push, do_pop;
		assign do_push = fifo_push[ch] && lvl != LVL_FULL;
		assign do_pop = fifo_pop[ch] && lvl != '0;
		always_ff @(posedge sys_clk or negedge resetn) begin
			if (!resetn) begin
				wp <= '0;
				rp <= '0;
				lvl <= '0;
			end else if (port_rst[ch]) begin
				wp <= '0;
				rp <= '0;
				lvl <= '0;
			end else begin
				wp <= wp + AW'(do_push);
				rp <= rp + AW'(do_pop);
				lvl <= lvl + (AW+1)'(do_push) - (AW+1)'(do_pop);
			end
		end
		always_ff @(posedge sys_clk) begin
			if (do_push)
				fifo_mem[ch][wp] <= filt.par.data;
		end
		assign fifo_rdata[ch] = fifo_mem[ch][rp];
		assign fifo_empty[ch] = lvl == '0;
		assign fifo_af[ch] = lvl >= LVL_AF;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	par_irq_mirror_a: assert property ((mode_parallel && $past(mode_parallel) && $past(mode_parallel, 2))
		|-> msg_pending_irq_n == !$past(dsp_out_ready)) else $error("irq does not mirror ready");
	no_solicit_a: assert property ((!mode_parallel && !unsolicited_en && !armed && !read_request
		&& state == HMI_IDLE && !late) |=> msg_pending_irq_n) else $error("irq low unsolicited");
	unsol_drop_a: assert property ((!mode_parallel && unsolicited_en && dsp_out_ready && !late
		&& state == HMI_IDLE) |=> !msg_pending_irq_n) else $error("irq not low");
	read_low_a: assert property ((!mode_parallel && in_read && !msg_pending_irq_n && !at_n1
		&& !frame_end && !frame_begin) |=> !msg_pending_irq_n) else $error("irq rose early");
	high_hold_a: assert property ((!mode_parallel && late && !at_n && !frame_begin)
		|=> msg_pending_irq_n) else $error("irq fell before N");
	late_drop_a: assert property ((!mode_parallel && in_read && late && at_n && dsp_out_ready
		&& unsolicited_en) |=> !msg_pending_irq_n && null_pend) else $error("late drop");
	null_out_a: assert property ((load_tx && null_pend && !frame_end && !frame_begin)
		|=> tx_sh == `HMI_NULL_BYTE && dsp_out_ready == $past(dsp_out_ready)) else $error("null");
	busy_set_a: assert property (par_msg_wr |=> host_in_busy ##0 dsp_in_data == $past(filt.par.data))
		else $error("busy not set");
	ready_clear_a: assert property ((par_msg_rd && !dsp_msg_wr) |=> !dsp_out_ready)
		else $error("ready not cleared");
	pcm_af_set_a: assert property ((g_fifo[0].lvl == LVL_AF - 1'b1 && g_fifo[0].do_push
		&& !g_fifo[0].do_pop && !port_rst[0]) |=> pcm_fifo_almost_full) else $error("af");
	pcm_af_clr_a: assert property ((g_fifo[0].lvl == LVL_AF && g_fifo[0].do_pop
		&& !g_fifo[0].do_push) |=> !pcm_fifo_almost_full) else $error("af clear");

	late_case_c: cover property (late ##[1:200] (at_n && dsp_out_ready));
	ser_read_c: cover property (ser_take ##[1:400] (at_n1 && !dsp_out_ready));
	pcm_full_c: cover property (pcm_fifo_almost_full);
	par_msg_c: cover property (par_msg_wr ##[1:50] par_msg_rd);
endmodule : hmi_port
`default_nettype wire
